/* File: bench/ocd_host_model.sv */
// host model: frames words onto the serial load port
`timescale 1ns/100ps
module ocd_host_model
(
  output logic sclk_o,           // link clock, still between frames
  output logic select_load_n_o,  // frame select, active low
  output logic serial_in_o       // data toward the port
);
  initial {sclk_o, select_load_n_o, serial_in_o} = 3'b010;
  // shifts n bits of w msb first at a 6 ns period, then loads
  task automatic send(input logic [31:0] w, input int n);
    select_load_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in_o = w[i];
      #3 sclk_o = 1'b1;
      #3 sclk_o = 1'b0;
    end
    #4 select_load_n_o = 1'b1;
    serial_in_o = ~serial_in_o;  // stale data is not left standing
    #25;  // clock held still while the word executes
  endtask
endmodule

/* File: bench/ocd_serial_load_port_assertions.sv */
// pin-level checks of the serial load port
`timescale 1ns/100ps
module ocd_serial_load_port_assertions
#(parameter int unsigned NUM_CH = 8)
(
  input wire logic                   clk_i,
  input wire logic                   sys_rst_i,
  input wire logic                   sclk_i,
  input wire logic                   select_load_n_i,
  input wire logic                   serial_in_i,
  input wire logic                   async_clear_n_i,
  input wire logic                   chain_out_o,
  input wire ocd_pkg::ocd_code_arr_t dac_code_o,
  input wire logic [NUM_CH-1:0]      power_down_o,
  input wire logic                   exec_pulse_o
);
  logic [5:0] cnt_ff, nxt_cnt;  // link rises since clear, stops at 32
  always_comb nxt_cnt = cnt_ff + 6'(cnt_ff < 6'h20);
  always_ff @(posedge sclk_i or negedge async_clear_n_i)
    if (!async_clear_n_i) cnt_ff <= 6'h00;
    else cnt_ff <= nxt_cnt;
  property p_pls; @(posedge clk_i) disable iff (sys_rst_i) exec_pulse_o |=> !exec_pulse_o; endproperty
  a_pls: assert property (p_pls) else $error("long pulse");
  property p_lat; @(posedge clk_i) disable iff (sys_rst_i) $rose(select_load_n_i) |-> ##[1:4] exec_pulse_o; endproperty
  a_lat: assert property (p_lat) else $error("no execute");
  property p_src; @(posedge clk_i) disable iff (sys_rst_i) exec_pulse_o |-> $past(select_load_n_i, 2); endproperty
  a_src: assert property (p_src) else $error("execute in frame");
  property p_cod; @(posedge clk_i) disable iff (sys_rst_i) $changed(dac_code_o) |-> exec_pulse_o || !async_clear_n_i;
  endproperty
  a_cod: assert property (p_cod) else $error("stray code");
  property p_pdn; @(posedge clk_i) disable iff (sys_rst_i) $changed(power_down_o) |-> exec_pulse_o || !async_clear_n_i;
  endproperty
  a_pdn: assert property (p_pdn) else $error("stray flag");
  property p_clr; @(posedge clk_i) disable iff (sys_rst_i) !async_clear_n_i |-> dac_code_o == '0 && power_down_o == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_cle; @(posedge clk_i) disable iff (sys_rst_i) !async_clear_n_i |-> !exec_pulse_o && !chain_out_o; endproperty
  a_cle: assert property (p_cle) else $error("clear strobe");
  property p_chn; @(posedge sclk_i) disable iff (!async_clear_n_i) cnt_ff == 6'h20 |-> chain_out_o == $past(serial_in_i, 32);
  endproperty
  a_chn: assert property (p_chn) else $error("chain");
endmodule
bind ocd_serial_load_port ocd_serial_load_port_assertions #(.NUM_CH(NUM_CH)) u_chk (
  .clk_i           (clk_i),
  .sys_rst_i       (sys_rst_i),
  .sclk_i          (sclk_i),
  .select_load_n_i (select_load_n_i),
  .serial_in_i     (serial_in_i),
  .async_clear_n_i (async_clear_n_i),
  .chain_out_o     (chain_out_o),
  .dac_code_o      (dac_code_o),
  .power_down_o    (power_down_o),
  .exec_pulse_o    (exec_pulse_o)
);

/* File: bench/ocd_serial_load_port_test.sv */
// bench of the serial load port against a reference model
`timescale 1ns/100ps
module ocd_serial_load_port_test;
  localparam int W = $bits(ocd_pkg::ocd_code_arr_t) + 8;  // codes and flags
  logic clk_i = 1'b0, sys_rst_i = 1'b1, async_clear_n_i = 1'b1;
  logic sclk_i, select_load_n_i, serial_in_i, chain_out_o, exec_pulse_o;
  logic [7:0] power_down_o, pd;  // flags seen and expected
  ocd_pkg::ocd_code_arr_t dac_code_o, dac, inr;  // codes seen, expected active and input
  int fail_count, samples_checked, execs;
  logic [31:0] w, sh;  // frame sent, expected shift register contents
  always #2.5 clk_i = ~clk_i;
  always @(negedge clk_i) if (exec_pulse_o === 1'b1) execs++;
  ocd_host_model host (.sclk_o(sclk_i), .select_load_n_o(select_load_n_i), .serial_in_o(serial_in_i));
  ocd_serial_load_port dut (
    .clk_i           (clk_i),
    .sys_rst_i       (sys_rst_i),
    .sclk_i          (sclk_i),
    .select_load_n_i (select_load_n_i),
    .serial_in_i     (serial_in_i),
    .async_clear_n_i (async_clear_n_i),
    .chain_out_o     (chain_out_o),
    .dac_code_o      (dac_code_o),
    .power_down_o    (power_down_o),
    .exec_pulse_o    (exec_pulse_o)
  );
  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // applies one word to the expected registers
  task automatic apply(input logic [3:0] c, a, input logic [15:0] d);
    for (int n = 0; n < 8; n++)
    begin
      if ((a == n || a == 4'hF) && c inside {4'h0, 4'h2, 4'h3}) inr[n] = d;
      if ((a == n || a == 4'hF) && c == 4'h4) pd[n] = 1'b1;
      if ((a == n || a == 4'hF) && c inside {4'h1, 4'h3} || c == 4'h2)
        {pd[n], dac[n]} = {1'b0, inr[n]};
    end
  endtask
  initial
  begin
    void'($urandom(32'h9FDD5D11));
    async_clear_n_i <= 1'b0;  // a real falling edge, so the link side clears too
    repeat (16) @(negedge clk_i);
    sys_rst_i <= 1'b0;
    for (int k = 0; k < 60; k++)
    begin
      if (k % 30 == 0)
      begin
        async_clear_n_i <= 1'b0;
        #1 chk({dac_code_o, power_down_o}, '0);
        {dac, inr, pd} = '0;
        sh = '0;
        repeat (4) @(negedge clk_i);
        async_clear_n_i <= 1'b1;
      end
      @(negedge clk_i) w = $urandom;
      w[23:20] = 4'(k % 8) ^ (k % 8 > 4 ? 4'hA : 4'h0);
      host.send(w, k % 3 ? 24 : 32);
      sh = (k % 3) ? {sh[7:0], w[23:0]} : w;
      apply(w[23:20], w[19:16], w[15:0]);
      @(negedge clk_i) chk({dac_code_o, power_down_o}, {dac, pd});
      chk(W'(execs), W'(k + 1));
      chk(W'(chain_out_o), W'(sh[31]));
      if (k % 30 == 29) $display("test %0d done", k / 30);
    end
    complete_run;
  end
  initial
  begin
    #50000;
    fail_count++;
    complete_run;
  end
endmodule

/* File: design/ocd_pkg.sv */
// shared constants and types of the octal converter serial load port
package ocd_pkg;

  // channel and word geometry
  localparam int unsigned NUM_CH     = 8;    // converter channels
  localparam int unsigned CODE_W     = 16;   // data field width
  localparam int unsigned SHIFT_LEN  = 32;   // shift register length, also chain delay
  localparam int unsigned WORD_LEN   = 24;   // ordinary command word length
  localparam int unsigned FIELD_W    = 4;    // command and channel field width
  localparam int unsigned SYNC_STAGES = 2;   // synchroniser depth on the select line

  // command field codes
  localparam logic [3:0] CMD_WRITE        = 4'h0;  // write input register
  localparam logic [3:0] CMD_UPDATE       = 4'h1;  // update converter register
  localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2; // write one, update all
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;  // write and update
  localparam logic [3:0] CMD_POWER_DOWN   = 4'h4;  // power down channel
  localparam logic [3:0] CMD_NOP          = 4'hF;  // no operation

  // channel select code that addresses every channel
  localparam logic [3:0] CH_ALL = 4'hF;

  // values after reset or clear
  localparam logic [CODE_W-1:0]    CODE_RST  = 16'h0000;  // zero scale
  localparam logic [SHIFT_LEN-1:0] SHIFT_RST = 32'h0000_0000;
  localparam logic [NUM_CH-1:0]    PD_RST    = 8'h00;     // all channels powered

  // one decoded command word, most significant field first on the wire
  typedef struct packed {
    logic [FIELD_W-1:0] command_field;         // what to do
    logic [FIELD_W-1:0] channel_select_field;  // which channel, or all
    logic [CODE_W-1:0]  data;                  // left-justified code
  } ocd_word_t;

  // per-channel codes as one packed carrier
  typedef logic [NUM_CH-1:0][CODE_W-1:0] ocd_code_arr_t;

endpackage

/* File: design/ocd_serial_load_port.sv */
// serial load port: link-side shift register and system-side channel registers
`timescale 1ns/100ps

// Contract
// (R1) low select frames a shifting transfer
// (R2) select rising stops shifting, runs command
// (R3) input bit captured on rising link edge
// (R4) 24-bit or 32-bit words both accepted
// (R5) chain output: bit after 32 edges, falling
// (R6) low clear empties all registers asynchronously
// (R7) word is command, channel, 16-bit data
// (R8) decode write, update, power-down, nop; reserved ignored
// (R9) 32-bit word: first eight bits ignored
// (R10) update copies input, restores from power-down
module ocd_serial_load_port
#(
  parameter int unsigned NUM_CH = ocd_pkg::NUM_CH   // channel count
)
(
  input  wire logic                  clk_i,            // system clock, 200 MHz
  input  wire logic                  sys_rst_i,        // synchronous reset, active high
  input  wire logic                  sclk_i,           // link serial clock
  input  wire logic                  select_load_n_i,  // frame select / load, active low
  input  wire logic                  serial_in_i,      // serial data in
  input  wire logic                  async_clear_n_i,  // asynchronous clear, active low
  output logic                       chain_out_o,      // daisy-chain serial out
  output ocd_pkg::ocd_code_arr_t     dac_code_o,       // active converter codes
  output logic [NUM_CH-1:0]          power_down_o,     // per-channel power-down state
  output logic                       exec_pulse_o      // one-cycle pulse per executed word
);

  // ---------------- link clock domain ----------------

  logic [ocd_pkg::SHIFT_LEN-1:0] shift_ff;       // input shift register
  logic [ocd_pkg::SHIFT_LEN-1:0] nxt_shift;      // its next value
  logic                          chain_ff;       // falling-edge copy of the last stage

  // shift only while select is low; the link clock is ignored otherwise
  always_comb
  begin
    nxt_shift = shift_ff;
    if (!select_load_n_i)
    begin
      nxt_shift = {shift_ff[ocd_pkg::SHIFT_LEN-2:0], serial_in_i};  // (R1) (R3)
    end
  end

  // shift register, emptied by the clear pin whatever the link clock does
  always_ff @(posedge sclk_i or negedge async_clear_n_i)
  begin
    if (!async_clear_n_i)
    begin
      shift_ff <= ocd_pkg::SHIFT_RST;  // (R6)
    end
    else
    begin
      shift_ff <= nxt_shift;
    end
  end

  // last stage re-driven on the falling edge for the next device in the chain
  always_ff @(negedge sclk_i or negedge async_clear_n_i)
  begin
    if (!async_clear_n_i)
    begin
      chain_ff <= 1'b0;
    end
    else
    begin
      chain_ff <= shift_ff[ocd_pkg::SHIFT_LEN-1];  // (R5)
    end
  end

  assign chain_out_o = chain_ff;

  // ---------------- system clock domain ----------------

  logic [ocd_pkg::SYNC_STAGES-1:0] clr_sync_ff;   // clear release synchroniser, bit 0 is the first stage
  logic                            clr_n;         // clear, asserted at once, released on the clock

  // the clear pin drops both stages at once; its release walks through two stages
  // so that no channel register leaves its cleared state close to a clock edge
  always_ff @(posedge clk_i or negedge async_clear_n_i)
  begin
    if (!async_clear_n_i)
    begin
      clr_sync_ff <= '0;  // (R6)
    end
    else
    begin
      clr_sync_ff <= {clr_sync_ff[0], 1'b1};
    end
  end

  assign clr_n = clr_sync_ff[ocd_pkg::SYNC_STAGES-1];

  logic [ocd_pkg::SYNC_STAGES-1:0] sel_sync_ff;   // select synchroniser, bit 0 is the first stage
  logic                            sel_prev_ff;   // previous synchronised select
  logic                            load_evt;      // select rising seen in this domain
  ocd_pkg::ocd_word_t              word;          // low 24 bits of the stable shift register

  // the first stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sel_sync_ff <= '1;
      sel_prev_ff <= 1'b1;
    end
    else
    begin
      sel_sync_ff <= {sel_sync_ff[0], select_load_n_i};
      sel_prev_ff <= sel_sync_ff[ocd_pkg::SYNC_STAGES-1];
    end
  end

  // rising select: shifting has stopped, so the shift register is quiet to read
  assign load_evt = sel_sync_ff[ocd_pkg::SYNC_STAGES-1] & ~sel_prev_ff;  // (R2)

  // taking only the newest 24 bits serves both word lengths; leading bits fall off
  assign word = ocd_pkg::ocd_word_t'(shift_ff[ocd_pkg::WORD_LEN-1:0]);  // (R4) (R7) (R9)

  // true when the channel select field names channel ch
  function automatic logic hits(input logic [3:0] sel, input int unsigned ch);
    hits = (sel == ocd_pkg::CH_ALL) || (sel == 4'(ch));
  endfunction

  ocd_pkg::ocd_code_arr_t input_ff;       // input registers
  ocd_pkg::ocd_code_arr_t nxt_input;
  ocd_pkg::ocd_code_arr_t conv_ff;        // converter registers, the active codes
  ocd_pkg::ocd_code_arr_t nxt_conv;
  logic [NUM_CH-1:0]      pd_ff;          // power-down flags
  logic [NUM_CH-1:0]      nxt_pd;
  logic                   exec_ff;        // execute pulse register
  logic                   nxt_exec;

  // command decode and execution on each load event
  always_comb
  begin
    nxt_input = input_ff;
    nxt_conv  = conv_ff;
    nxt_pd    = pd_ff;
    nxt_exec  = load_evt;
    if (load_evt)
    begin
      for (int unsigned ch = 0; ch < NUM_CH; ch++)
      begin
        unique case (word.command_field)  // (R8)
          ocd_pkg::CMD_WRITE:
          begin
            if (hits(word.channel_select_field, ch))
            begin
              nxt_input[ch] = word.data;
            end
          end
          ocd_pkg::CMD_UPDATE:
          begin
            if (hits(word.channel_select_field, ch))
            begin
              nxt_conv[ch] = input_ff[ch];  // (R10)
              nxt_pd[ch]   = 1'b0;
            end
          end
          ocd_pkg::CMD_WRITE_UPD_ALL:
          begin
            // every channel updates; the written one takes the new code
            if (hits(word.channel_select_field, ch))
            begin
              nxt_input[ch] = word.data;
              nxt_conv[ch]  = word.data;
            end
            else
            begin
              nxt_conv[ch] = input_ff[ch];  // (R10)
            end
            nxt_pd[ch] = 1'b0;
          end
          ocd_pkg::CMD_WRITE_UPDATE:
          begin
            if (hits(word.channel_select_field, ch))
            begin
              nxt_input[ch] = word.data;
              nxt_conv[ch]  = word.data;  // (R10)
              nxt_pd[ch]    = 1'b0;
            end
          end
          ocd_pkg::CMD_POWER_DOWN:
          begin
            // data field is ignored; register contents stay
            if (hits(word.channel_select_field, ch))
            begin
              nxt_pd[ch] = 1'b1;
            end
          end
          default:
          begin
            // no operation and reserved codes change nothing
          end
        endcase
      end
    end
  end

  // channel registers: clear pin acts at once, system reset on the clock
  always_ff @(posedge clk_i or negedge clr_n)
  begin
    if (!clr_n)
    begin
      input_ff <= '{default: ocd_pkg::CODE_RST};  // (R6)
      conv_ff  <= '{default: ocd_pkg::CODE_RST};  // (R6)
      pd_ff    <= ocd_pkg::PD_RST;
      exec_ff  <= 1'b0;
    end
    else if (sys_rst_i)
    begin
      input_ff <= '{default: ocd_pkg::CODE_RST};
      conv_ff  <= '{default: ocd_pkg::CODE_RST};
      pd_ff    <= ocd_pkg::PD_RST;
      exec_ff  <= 1'b0;
    end
    else
    begin
      input_ff <= nxt_input;
      conv_ff  <= nxt_conv;
      pd_ff    <= nxt_pd;
      exec_ff  <= nxt_exec;
    end
  end

  assign dac_code_o   = conv_ff;
  assign power_down_o = pd_ff;
  assign exec_pulse_o = exec_ff;

endmodule
